/* rtl/lcp_defs.vh */
// Constants for the LED channel PWM and diagnostic control block.
// Assumes a 10 MHz system clock and serial pins synchronised inside.
`ifndef LCP_DEFS_VH
`define LCP_DEFS_VH
// Latch keys, counted in serial clock rising edges
`define LCP_KEY_SWITCH 4'h2
`define LCP_KEY_DATA 4'h4
`define LCP_KEY_GLOBAL 4'h6
`define LCP_KEY_OPEN 4'h9
`define LCP_KEY_SHORT 4'ha
`define LCP_KEY_COMB 4'hb
`define LCP_KEY_DETEND 4'hc
`define LCP_KEY_THERM 4'hd
// Configuration field positions
`define LCP_CFG_SHTH_LO 8
`define LCP_CFG_SHTH_HI 9
`define LCP_CFG_DET 7
`define LCP_CFG_AUTO 10
`define LCP_CFG_SLEW_LO 11
`define LCP_CFG_SLEW_HI 12
`define LCP_CFG_SDOF 13
`define LCP_CFG_NOGRAD 14
`define LCP_CFG_PWM12 15
`define LCP_CFG_RST 16'h0000
// APB register byte offsets
`define LCP_OFF_CFG 8'h00
`define LCP_OFF_STAT 8'h04
`define LCP_OFF_SW 8'h08
// Timing
`define LCP_CLK_NS 100
`define LCP_STAG_NS 10
`define LCP_STAG_CYC (((`LCP_STAG_NS / `LCP_CLK_NS) < 1) ? 1 : \
   (`LCP_STAG_NS / `LCP_CLK_NS))
`endif

/* rtl/lcp_led_ctrl.v */
// Control logic of a 16-channel LED driver: serial load, PWM, diagnostics.
// Assumes serial, strobe and PWM clock pins are asynchronous to clk and
// slower than clk/4; analog comparators deliver static fault flags.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lcp_defs.vh"
//
// Overview of operation
//
// The display controller talks to this block over four pins: a serial
// clock, a serial data line, a latch strobe and a separate PWM counter
// clock. None of these share the system clock, so every one of them goes
// through a two-stage synchroniser. A third stage on the clock-like pins
// gives the edge detectors a clean previous value to compare against.
//
// Commands are not carried as opcodes. Instead the controller holds the
// latch strobe high across the last few serial clock rising edges of a
// word, and the number of edges seen while the strobe stood high is the
// command key. The key is decoded only when the strobe falls, so a key is
// never acted upon half counted.
//
// Brightness words arrive one per channel, highest channel first. Each
// but the last is parked in a temporary buffer by the data latch key; the
// global latch key parks the last word and copies every buffer into the
// active brightness registers in the same clock, so the display never
// shows a mix of old and new frames.
//
// The PWM comparison runs against a free counter that advances only on
// the PWM clock pin. Until that pin toggles the counter sits at zero, so
// any channel whose compared brightness bits (the low 12 in 12-bit mode) are non-zero is simply on.
//
// Diagnostics: a start key arms open, short or combined checking, the
// end key freezes the per-channel verdict into the error data register,
// and the following serial clock edges shift it out, channel 15 first.
// The thermal key loads the same register with all ones or all zeros.
//
// Auto shutdown, when enabled, darkens every channel once an all-zero
// switch word is latched and refuses every key but the switch latch until
// a word with any bit set arrives.
//
// Configuration lives behind a small APB slave with no wait states.
// Limitation: serial pins must be slower than a quarter of clk, or edges
// are lost in the synchronisers; there is no error flag for that case.
//
module lcp_led_ctrl #(
   parameter NCH = 16,
   parameter BW = 16
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Serial link pins
   input wire serialClk,
   input wire serialIn,
   input wire latchStrobe,
   input wire pwmCountClock,
   output reg serialOut,
   // Analog side
   input wire [NCH-1:0] currentLow,
   input wire [NCH-1:0] voltageHigh,
   input wire overTemp,
   output wire [1:0] shortThreshSel,
   output wire [1:0] slewSel,
   output reg powerDown,
   output reg [NCH-1:0] channelOutputs
);
   localparam [1:0] DET_IDLE = 2'h0;
   localparam [1:0] DET_OPEN = 2'h1;
   localparam [1:0] DET_SHORT = 2'h2;
   localparam [1:0] DET_COMB = 2'h3;

   reg [15:0] cfg_q;
   reg [2:0] sck_q, le_q, pck_q;
   reg [1:0] sdi_q, tmp_q;
   // Analog fault flags resynchronised before the verdict logic reads them
   reg [NCH-1:0] curLow1_q, curLow2_q;
   reg [NCH-1:0] volHigh1_q, volHigh2_q;
   reg [1:0] detMode_q;
   reg [3:0] edgeCnt_q;
   reg [3:0] ptr_q;
   reg [BW-1:0] shift_q;
   reg [15:0] outShift_q;
   reg [15:0] errorData_q;
   reg [NCH-1:0] switch_q;
   reg [BW-1:0] tmpBuf [0:NCH-1];
   reg [BW-1:0] bright [0:NCH-1];
   reg [15:0] pwmCnt_q;
   reg [NCH-1:0] stag_q;
   reg [7:0] stagCnt_q;
   reg sdoBit_q;
   integer k;

   wire sckRise = sck_q[1] & ~sck_q[2];
   wire sckFall = ~sck_q[1] & sck_q[2];
   wire leFall = ~le_q[1] & le_q[2];
   wire pckRise = pck_q[1] & ~pck_q[2];
   wire is12 = cfg_q[`LCP_CFG_PWM12];
   wire apbWr = psel & penable & pwrite & pready;
   wire hit = (paddr == `LCP_OFF_CFG) | (paddr == `LCP_OFF_STAT) |
      (paddr == `LCP_OFF_SW);
   wire [15:0] cntTop = is12 ? 16'h0fff : 16'hffff;
   wire pwmWrap = pckRise & (pwmCnt_q == cntTop);
   wire detOn = ~cfg_q[`LCP_CFG_DET];
   wire [NCH-1:0] detOk;
   wire [NCH-1:0] pwmOn;

   // Analog settings come straight from configuration flops
   assign shortThreshSel = cfg_q[`LCP_CFG_SHTH_HI:`LCP_CFG_SHTH_LO];
   assign slewSel = cfg_q[`LCP_CFG_SLEW_HI:`LCP_CFG_SLEW_LO];

   // Two-stage synchronisers; edge detection compares the second stage with the third
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sck_q <= 3'h0;
         le_q <= 3'h0;
         pck_q <= 3'h0;
         sdi_q <= 2'h0;
         tmp_q <= 2'h0;
         curLow1_q <= {NCH{1'b0}};
         curLow2_q <= {NCH{1'b0}};
         volHigh1_q <= {NCH{1'b0}};
         volHigh2_q <= {NCH{1'b0}};
      end else begin
         sck_q <= {sck_q[1:0], serialClk};
         le_q <= {le_q[1:0], latchStrobe};
         pck_q <= {pck_q[1:0], pwmCountClock};
         sdi_q <= {sdi_q[0], serialIn};
         tmp_q <= {tmp_q[0], overTemp};
         // Comparator outputs settle slowly; two flops are plenty
         curLow1_q <= currentLow;
         curLow2_q <= curLow1_q;
         volHigh1_q <= voltageHigh;
         volHigh2_q <= volHigh1_q;
      end
   end

   // APB slave: zero wait states, answers in the first access cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         cfg_q <= `LCP_CFG_RST;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         // Writes return zero read data so a refused write shows no stale word
         if (psel & ~penable & pwrite)
            prdata <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `LCP_OFF_CFG: prdata <= {16'h0000, cfg_q};
               `LCP_OFF_STAT: prdata <= {errorData_q, 12'h000, detMode_q,
                  tmp_q[1], powerDown};
               `LCP_OFF_SW: prdata <= {16'h0000, switch_q};
               default: prdata <= 32'h00000000;
            endcase
         end
         // Status and switch are read-only; writes there are dropped
         if (apbWr & (paddr == `LCP_OFF_CFG))
            cfg_q <= pwdata[15:0];
      end
   end

   // Detection outcome per channel, one means healthy
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gCh
         assign detOk[g] = ~switch_q[g] |
            (((detMode_q == DET_OPEN) | (detMode_q == DET_COMB)) ?
               ~curLow2_q[g] : 1'b1) &
            (((detMode_q == DET_SHORT) | (detMode_q == DET_COMB)) ?
               ~volHigh2_q[g] : 1'b1);
         // Upper nibble masked out in the short counter mode
         assign pwmOn[g] = (is12 ? (bright[g][11:0] > pwmCnt_q[11:0])
            : (bright[g] > pwmCnt_q));
      end
   endgenerate

   // Serial shift, key counting and key decode.
   // The input shift register also feeds the output shifter, so a chain
   // of blocks passes words along when no readout is pending.
   // Any key but the switch latch that lands during shutdown is dropped
   // without trace; the controller has to resend it after waking the block.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shift_q <= {BW{1'b0}};
         edgeCnt_q <= 4'h0;
         ptr_q <= 4'hf;
         switch_q <= {NCH{1'b0}};
         detMode_q <= DET_IDLE;
         errorData_q <= 16'h0000;
         outShift_q <= 16'h0000;
         sdoBit_q <= 1'b0;
         powerDown <= 1'b0;
         for (k = 0; k < NCH; k = k + 1) begin
            tmpBuf[k] <= {BW{1'b0}};
            bright[k] <= {BW{1'b0}};
         end
      end else begin
         if (sckRise) begin
            shift_q <= {shift_q[BW-2:0], sdi_q[1]};
            sdoBit_q <= outShift_q[15];
            outShift_q <= {outShift_q[14:0], shift_q[BW-1]};
            // Count saturates so long holds never alias a short key
            if (le_q[1] & (edgeCnt_q != 4'hf))
               edgeCnt_q <= edgeCnt_q + 4'h1;
         end
         if (leFall) begin
            edgeCnt_q <= 4'h0;
            if (edgeCnt_q == `LCP_KEY_SWITCH) begin
               switch_q <= shift_q[NCH-1:0];
               if (cfg_q[`LCP_CFG_AUTO])
                  powerDown <= (shift_q[NCH-1:0] == {NCH{1'b0}});
            end else if (!powerDown) begin
               case (edgeCnt_q)
                  `LCP_KEY_DATA: begin
                     tmpBuf[ptr_q] <= shift_q;
                     ptr_q <= ptr_q - 4'h1;
                  end
                  `LCP_KEY_GLOBAL: begin
                     for (k = 0; k < NCH; k = k + 1)
                        bright[k] <= (k == ptr_q) ? shift_q : tmpBuf[k];
                     tmpBuf[ptr_q] <= shift_q;
                     ptr_q <= 4'hf;
                  end
                  `LCP_KEY_OPEN:
                     if (detOn) detMode_q <= DET_OPEN;
                  `LCP_KEY_SHORT:
                     if (detOn) detMode_q <= DET_SHORT;
                  `LCP_KEY_COMB:
                     if (detOn) detMode_q <= DET_COMB;
                  `LCP_KEY_DETEND:
                     if (detMode_q != DET_IDLE) begin
                        errorData_q <= detOk;
                        outShift_q <= detOk;
                        detMode_q <= DET_IDLE;
                     end
                  `LCP_KEY_THERM: begin
                     errorData_q <= {16{tmp_q[1]}};
                     outShift_q <= {16{tmp_q[1]}};
                  end
                  default: ;
               endcase
            end
         end
         // Clearing the auto bit powers the device up again
         if (!cfg_q[`LCP_CFG_AUTO])
            powerDown <= 1'b0;
      end
   end

   // Serial output: rising edge by default, falling edge on request.
   // The falling-edge choice gives a chained neighbour half a serial
   // period of extra hold time at the cost of half a period of latency.
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         serialOut <= 1'b0;
      else if (cfg_q[`LCP_CFG_SDOF] ? sckFall : sckRise)
         serialOut <= cfg_q[`LCP_CFG_SDOF] ? sdoBit_q : outShift_q[15];
   end

   // PWM counter runs only on PWM clock edges; wraps at the mode's top.
   // Switching width mid-frame: a count already above the new top misses the wrap test, runs on to 16'hffff and overflows to zero without pwmWrap.
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         pwmCnt_q <= 16'h0000;
      else if (pckRise)
         pwmCnt_q <= pwmWrap ? 16'h0000 : pwmCnt_q + 16'h0001;
   end

   // Turn-on stagger: one more channel released each step after a wrap.
   // At 10 MHz the step cannot be finer than one clock.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stag_q <= {{NCH-1{1'b0}}, 1'b1};
         stagCnt_q <= 8'h00;
      end else if (pwmWrap) begin
         stag_q <= {{NCH-1{1'b0}}, 1'b1};
         stagCnt_q <= 8'h00;
      end else if (stagCnt_q == (`LCP_STAG_CYC - 1)) begin
         stag_q <= {stag_q[NCH-2:0], 1'b1};
         stagCnt_q <= 8'h00;
      end else
         stagCnt_q <= stagCnt_q + 8'h01;
   end

   // Channel drive: PWM, switch, stagger and power state combined.
   // Registered so the pins never glitch while the comparators settle.
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         channelOutputs <= {NCH{1'b0}};
      else
         channelOutputs <= pwmOn & switch_q & {NCH{~powerDown}} &
            (stag_q | {NCH{cfg_q[`LCP_CFG_NOGRAD]}});
   end
endmodule

/* bench/lcp_led_ctrl_assertions.sv */
// Port-level checker for the LED channel PWM and diagnostic control block.
// Assumes it is bound into lcp_led_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module lcp_led_ctrl_assertions #(
   parameter NCH = 16,
   parameter BW = 16
) (
   // Clock, reset and APB slave
   input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // Serial pins and analog side
   input wire logic serialClk, serialIn, latchStrobe, pwmCountClock,
   input wire logic serialOut, overTemp, powerDown,
   input wire logic [NCH-1:0] currentLow, voltageHigh, channelOutputs,
   input wire logic [1:0] shortThreshSel, slewSel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Completed APB transfers
   wire done = psel && penable && pready;
   wire wrCfg = done && pwrite && paddr == 8'h00;
   wire rdAcc = done && !pwrite;
   // Outputs lag powerDown by one register, so two cycles are needed
   sequence sleeping2;
      powerDown ##1 powerDown;
   endsequence
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_err_unmapped: assert property (done && (paddr > 8'h08 ||
      paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (rdAcc && paddr == 8'h00 |->
      prdata[31:16] == 16'h0) else $error("config upper half not zero");
   a_cfg_fields: assert property (wrCfg |=>
      shortThreshSel == $past(pwdata[9:8]) &&
      slewSel == $past(pwdata[12:11])) else $error("config fields stale");
   a_auto_off: assert property (wrCfg && !pwdata[10] |->
      ##[1:2] !powerDown) else $error("shutdown kept with bit clear");
   a_sleep_dark: assert property (sleeping2 |->
      channelOutputs == '0) else $error("channel on while shut down");
   a_stat_sleep: assert property (rdAcc && paddr == 8'h04 |->
      prdata[0] == powerDown) else $error("status shutdown bit wrong");
endmodule
bind lcp_led_ctrl lcp_led_ctrl_assertions #(.NCH(NCH), .BW(BW)) chk_u (.*);

/* bench/lcp_ctrl_partner.sv */
// Display controller model: drives serial clock, data and latch strobe.
// Assumes the serial clock stands low between frames, 800 ns period.
`timescale 1ns/1ps
module lcp_ctrl_partner (
   // Serial link
   output logic serialClk,
   output logic serialIn,
   output logic latchStrobe,
   input wire logic serialOut
);
   initial begin
      serialClk = 1'b0;
      serialIn = 1'b0;
      latchStrobe = 1'b0;
   end
   // Whole 16-bit word, MSB first; strobe rides over the last key edges
   task automatic send(input logic [15:0] w, input int key);
      for (int i = 15; i >= 0; i--) begin
         serialIn = w[i];
         latchStrobe = (i < key);
         #400 serialClk = 1'b1;
         #400 serialClk = 1'b0;
      end
      latchStrobe = 1'b0;
      // Released data line must not keep a plausible value
      serialIn = ~serialIn;
      #800;
   endtask
   // Sample each bit just before the next rise, after the sync delay
   task automatic read(output logic [15:0] r);
      for (int i = 15; i >= 0; i--) begin
         serialClk = 1'b1;
         #400 serialClk = 1'b0;
         #350 r[i] = serialOut;
         #50;
      end
      #800;
   endtask
endmodule

/* bench/lcp_led_ctrl_test.sv */
// Self-checking bench for the LED channel control block.
// Assumes lcp_led_ctrl, its checker and the controller model are compiled.
`timescale 1ns/1ps
module lcp_led_ctrl_test;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;
      logic [31:0] e; logic err;} lcp_row_t;
   logic clk, resetn, psel, penable, pwrite, pwmCountClock, overTemp, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd;
   logic [15:0] currentLow, voltageHigh, r16;
   wire [31:0] prdata;
   wire pready, pslverr, serialClk, serialIn, latchStrobe, serialOut;
   wire powerDown;
   wire [1:0] shortThreshSel, slewSel;
   wire [15:0] channelOutputs;
   int error_cnt = 0;
   int comparisons = 0;
   // Register cases: access, address, write data, read value, error
   lcp_row_t rows [6] = '{'{0, 8'h00, 0, 0, 0},
      '{1, 8'h00, 32'hffff1b00, 0, 0}, '{0, 8'h00, 0, 32'h1b00, 0},
      '{1, 8'h08, 32'h1, 0, 0}, '{0, 8'h08, 0, 0, 0},
      '{0, 8'h0c, 0, 0, 1}};
   lcp_led_ctrl dut_u (.*);
   lcp_ctrl_partner partner_u (.*);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // APB master: hold the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1) error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic therm(input logic [31:0] exp);
      partner_u.send(16'h0, 13);
      partner_u.read(r16);
      chk({16'h0, r16}, exp);
   endtask
   task automatic print_verdict();
      $display("errors %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog sized well above the roughly 0.4 ms of traffic
   initial begin
      #3000000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      {resetn, psel, penable, pwrite, pwmCountClock, overTemp} = 6'h0;
      {paddr, pwdata, currentLow, voltageHigh} = '0;
      waitc(4);
      resetn <= 1'b1;
      chk({16'h0, channelOutputs}, 32'h0);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) chk(rd, rows[i].e);
         chk({31'h0, err}, {31'h0, rows[i].err});
      end
      // Channel c gets brightness c, then all switched on
      for (int c = 15; c > 0; c--) partner_u.send(16'(c), 4);
      partner_u.send(16'h0, 6);
      partner_u.send(16'hffff, 2);
      waitc(40);
      chk({16'h0, channelOutputs}, 32'hfffe);
      repeat (3) begin
         waitc(4);
         pwmCountClock <= 1'b1;
         waitc(4);
         pwmCountClock <= 1'b0;
      end
      waitc(40);
      chk({16'h0, channelOutputs}, 32'hfff0);
      currentLow <= 16'h0030;
      partner_u.send(16'h0, 9);
      waitc(20);
      partner_u.send(16'h0, 12);
      partner_u.read(r16);
      chk({16'h0, r16}, 32'hffcf);
      overTemp <= 1'b1;
      therm(32'hffff);
      overTemp <= 1'b0;
      therm(32'h0);
      // Auto shutdown on all-zero switch data, wake on a set bit
      apb(1'b1, 8'h00, 32'h1f00);
      partner_u.send(16'h0, 2);
      waitc(20);
      chk({31'h0, powerDown}, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      partner_u.send(16'hffff, 2);
      waitc(40);
      chk({31'h0, powerDown}, 32'h0);
      chk({16'h0, channelOutputs}, 32'hfff0);
      // Readout moved to the falling serial clock edge
      overTemp <= 1'b1;
      apb(1'b1, 8'h00, 32'h2000);
      therm(32'hffff);
      print_verdict();
   end
endmodule
